// *** abu_cmp.sv ***
// full 16-bit break address comparator
// assumes sample is a one-cycle strobe per bus cycle from the controller
module abu_cmp (
	// comparator channel
	abu_cmp_if.cmp cif
);
	logic [15:0] diff;

	// per-bit equality, one xor per address bit
	genvar gi;
	generate
		for (gi = 0; gi < 16; gi++) begin : g_bit
			assign diff[gi] = cif.brk_addr[gi] ^ cif.pc_addr[gi];
		end
	endgenerate

	// only a sampled, armed cycle can hit
	assign cif.hit = cif.sample & cif.armed & ~(|diff);
endmodule

// *** abu_cmp_if.sv ***
// signals between the breakpoint unit and its address comparator
// assumes both ends run on the same bus clock
interface abu_cmp_if;
	logic [15:0] brk_addr;
	logic [15:0] pc_addr;
	logic sample;
	logic armed;
	logic hit;

	modport ctl (output brk_addr, output pc_addr, output sample, output armed, input hit);
	modport cmp (input brk_addr, input pc_addr, input sample, input armed, output hit);
endinterface

// *** abu_cpu_model.sv ***
// cpu stand-in: opcode, operand, data access, then boundary per instruction
// assumes a break is answered by a fixed-length handler ending in a return
module abu_cpu_model #(
	parameter int HOLD = 16
) (
	// clock and control
	input wire logic ref_clk,
	input wire logic go,
	input wire logic cpu_low_power,
	input wire logic breakpoint_request,
	// bus status toward the unit
	output logic [15:0] cpu_addr,
	output logic cpu_bus_cycle,
	output logic cpu_addr_from_pc,
	output logic cpu_opcode_fetch,
	output logic cpu_instr_boundary,
	output logic cpu_rti_done
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] pc_r = 16'h0100;
	logic [1:0] ph_r = 2'h0;
	logic [5:0] hold_r = 6'h00;
	// sequencing; a break restarts the held pc, so a broken opcode is fetched again
	always @(posedge ref_clk) begin
		cpu_rti_done <= hold_r == 6'h01;
		if (hold_r != 6'h00)
			hold_r <= hold_r - 6'h01;
		else if (breakpoint_request) begin
			hold_r <= 6'(HOLD);
			ph_r <= 2'h0;
		end else if (!go) begin
			pc_r <= 16'h0100;
			ph_r <= 2'h0;
		end else if (!cpu_low_power) begin
			ph_r <= ph_r + 2'h1;
			if (ph_r == 2'h3)
				pc_r <= pc_r + 16'h0002;
		end
	end
	// idle bus shows the inverted pc so a stale address cannot match
	always_comb begin
		cpu_bus_cycle = hold_r == 6'h00 && ph_r != 2'h3;
		cpu_addr = !cpu_bus_cycle ? ~pc_r : ph_r == 2'h2 ? 16'h0080 : pc_r + 16'(ph_r);
		cpu_addr_from_pc = ph_r != 2'h2;
		cpu_opcode_fetch = ph_r == 2'h0;
		cpu_instr_boundary = ph_r == 2'h3 && hold_r == 6'h00 && go && !cpu_low_power;
	end
endmodule

// *** abu_pkg.sv ***
// constants and types of the address breakpoint unit
// assumes one bus clock and a cpu that reports fetches once per bus cycle
package abu_pkg;
	// register indices on the byte-wide register port
	localparam logic [2:0] ADDR_CTRL_STATUS = 3'h0;
	localparam logic [2:0] ADDR_BRK_HIGH = 3'h1;
	localparam logic [2:0] ADDR_BRK_LOW = 3'h2;
	localparam logic [2:0] ADDR_AUXILIARY = 3'h3;
	localparam logic [2:0] ADDR_WAIT_STATUS = 3'h4;
	localparam logic [2:0] ADDR_FLAG_CLEAR = 3'h5;

	// field positions
	localparam int BIT_BREAK_ENABLE = 7;
	localparam int BIT_BREAK_ACTIVE = 6;
	localparam int BIT_WD_DISABLE = 0;
	localparam int BIT_WAIT_EXIT = 1;
	localparam int BIT_FLAG_CLEAR_EN = 7;

	// reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [15:0] RST_ADDR = 16'h0000;

	// break vectors, normal and monitor mode
	localparam logic [15:0] VEC_NORMAL = 16'hfffc;
	localparam logic [15:0] VEC_MONITOR = 16'hfefc;

	// break sequencing states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_PEND = 2'b01,
		ST_REQ = 2'b10,
		ST_ACTIVE = 2'b11
	} abu_state_t;
endpackage

// *** abu_properties.sv ***
// assertions on the breakpoint unit's top ports
// assumes one clock and rst_b synchronous active low
module abu_properties (
	// clock and reset
	input logic ref_clk,
	input logic rst_b,
	// watched ports
	input logic cpu_rti_done,
	input logic monitor_mode,
	input logic breakpoint_request,
	input logic force_swi_instr,
	input logic [15:0] break_vector,
	input logic break_state,
	input logic status_clear_allow,
	input logic timer_freeze,
	input logic watchdog_halt
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (!rst_b);
	a_req_pulse: assert property (breakpoint_request |=> !breakpoint_request)
		else $error("request held too long");
	a_swi_pair: assert property (force_swi_instr == breakpoint_request)
		else $error("swi apart from request");
	a_vector_mode: assert property (breakpoint_request |->
		break_vector == ($past(monitor_mode) ? abu_pkg::VEC_MONITOR : abu_pkg::VEC_NORMAL))
		else $error("bad vector");
	a_req_enters: assert property (breakpoint_request |-> break_state && !$past(break_state))
		else $error("request outside a fresh break");
	a_rti_ends: assert property (break_state && cpu_rti_done |=> !break_state)
		else $error("break kept after return");
	a_timer_freeze: assert property (timer_freeze == break_state)
		else $error("timer freeze differs");
	a_clear_gate: assert property (!break_state |-> status_clear_allow)
		else $error("clearing blocked outside break");
	a_wd_cause: assert property (watchdog_halt |-> break_state && $past(monitor_mode))
		else $error("watchdog halted without cause");
	c_break: cover property (breakpoint_request);
	c_monitor: cover property (breakpoint_request && monitor_mode);
	c_wd: cover property (watchdog_halt);
endmodule
bind abu_top abu_properties u_props (.*);

// *** abu_top.sv ***
// address breakpoint unit: compares program addresses against a break address
// assumes the cpu core and system integration logic share ref_clk, so no
// input here needs a synchroniser; the cpu strobes one bus cycle at a time

// Notes on behaviour
// R1 - enabled address match requests a break
// R2 - compare only program counter generated addresses
// R3 - break forces swi, vector by mode
// R4 - writing one to active flag breaks
// R5 - return from interrupt ends break state
// R6 - opcode match breaks before instruction executes
// R7 - operand match breaks after instruction completes
// R8 - software break taken before next instruction
// R9 - no rebreak on unchanged address
// R10 - handler reloads address and clears flag
// R11 - software should break on opcode addresses
// R12 - enable is bit seven, reset clear
// R13 - match sets active flag, software clears
// R14 - break address high and low, reset clear
// R15 - flag clear enable gates status clearing
// R16 - timer frozen during break state
// R17 - watchdog off in monitor break if enabled
// R18 - watchdog disable bit read write, reset clear
// R19 - no match break in wait or stop
// R20 - flag shows wait exited by break
// R21 - sample once per bus cycle, only enabled
module abu_top (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// register port
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// cpu core status
	input wire logic [15:0] cpu_addr,
	input wire logic cpu_bus_cycle,
	input wire logic cpu_addr_from_pc,
	input wire logic cpu_opcode_fetch,
	input wire logic cpu_instr_boundary,
	input wire logic cpu_rti_done,
	input wire logic cpu_low_power,
	input wire logic cpu_wait_mode,
	input wire logic monitor_mode,
	// to system integration logic
	output logic breakpoint_request,
	output logic force_swi_instr,
	output logic [15:0] break_vector,
	output logic break_state,
	output logic status_clear_allow,
	output logic timer_freeze,
	output logic watchdog_halt
);
	abu_cmp_if cif ();

	logic break_enable_r;
	logic break_active_r;
	logic [7:0] addr_high_r;
	logic [7:0] addr_low_r;
	logic wd_disable_r;
	logic wait_exit_r;
	logic flag_clear_en_r;
	logic armed_r;
	abu_pkg::abu_state_t state_r;
	abu_pkg::abu_state_t state_nxt;
	logic wr_ctrl;
	logic wr_addr;
	logic sw_trigger;
	logic in_break_nxt;

	// write decode
	always_comb begin
		wr_ctrl = 1'b0;
		wr_addr = 1'b0;
		if (reg_wr && reg_addr == abu_pkg::ADDR_CTRL_STATUS) begin
			wr_ctrl = 1'b1;
		end else if (reg_wr && reg_addr == abu_pkg::ADDR_BRK_HIGH) begin
			wr_addr = 1'b1;
		end else if (reg_wr && reg_addr == abu_pkg::ADDR_BRK_LOW) begin
			wr_addr = 1'b1;
		end
	end

	// a written one only triggers outside a break already in progress
	assign sw_trigger = wr_ctrl & reg_wdata[abu_pkg::BIT_BREAK_ACTIVE]
		& (state_r == abu_pkg::ST_IDLE); // [R4]

	// comparator channel
	assign cif.brk_addr = {addr_high_r, addr_low_r}; // [R14]
	assign cif.pc_addr = cpu_addr;
	// address bus is frozen in wait and stop, so no match is sampled there
	assign cif.sample = cpu_bus_cycle & cpu_addr_from_pc & ~cpu_low_power; // [R2] [R19] [R21]
	assign cif.armed = break_enable_r & armed_r & (state_r == abu_pkg::ST_IDLE); // [R1] [R21]

	abu_cmp u_cmp (
		.cif(cif)
	);

	// enable bit, cleared by writing zero or by reset
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			break_enable_r <= 1'b0;
		end else if (wr_ctrl) begin
			break_enable_r <= reg_wdata[abu_pkg::BIT_BREAK_ENABLE]; // [R12]
		end
	end

	// active flag: hardware set wins over a software clear
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			break_active_r <= 1'b0;
		end else if (cif.hit || sw_trigger) begin
			break_active_r <= 1'b1; // [R13] [R21]
		end else if (wr_ctrl) begin
			break_active_r <= reg_wdata[abu_pkg::BIT_BREAK_ACTIVE]; // [R13]
		end
	end

	// break address bytes
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			addr_high_r <= abu_pkg::RST_BYTE; // [R14]
			addr_low_r <= abu_pkg::RST_BYTE;
		end else if (reg_wr && reg_addr == abu_pkg::ADDR_BRK_HIGH) begin
			addr_high_r <= reg_wdata;
		end else if (reg_wr && reg_addr == abu_pkg::ADDR_BRK_LOW) begin
			addr_low_r <= reg_wdata;
		end
	end

	// a hit disarms; only a fresh break address re-arms, so returning to a
	// still-matching address after the handler does not loop forever
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			armed_r <= 1'b1;
		end else if (cif.hit) begin
			armed_r <= 1'b0; // [R9]
		end else if (wr_addr) begin
			armed_r <= 1'b1; // [R10]
		end
	end

	// auxiliary and flag clear control bits
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			wd_disable_r <= 1'b0; // [R18]
			flag_clear_en_r <= 1'b0;
		end else if (reg_wr && reg_addr == abu_pkg::ADDR_AUXILIARY) begin
			wd_disable_r <= reg_wdata[abu_pkg::BIT_WD_DISABLE]; // [R18]
		end else if (reg_wr && reg_addr == abu_pkg::ADDR_FLAG_CLEAR) begin
			flag_clear_en_r <= reg_wdata[abu_pkg::BIT_FLAG_CLEAR_EN];
		end
	end

	// wait exit flag: set when a break is issued from wait, set wins
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			wait_exit_r <= 1'b0;
		end else if (state_nxt == abu_pkg::ST_REQ && cpu_wait_mode) begin
			wait_exit_r <= 1'b1; // [R20]
		end else if (reg_wr && reg_addr == abu_pkg::ADDR_WAIT_STATUS) begin
			wait_exit_r <= reg_wdata[abu_pkg::BIT_WAIT_EXIT];
		end
	end

	// break sequencing
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			abu_pkg::ST_IDLE: begin
				if (cif.hit && cpu_opcode_fetch) begin
					state_nxt = abu_pkg::ST_REQ; // [R6]
				end else if (cif.hit || sw_trigger) begin
					state_nxt = abu_pkg::ST_PEND; // [R7] [R8]
				end
			end
			abu_pkg::ST_PEND: begin
				if (cpu_instr_boundary) begin
					state_nxt = abu_pkg::ST_REQ; // [R7] [R8]
				end
			end
			abu_pkg::ST_REQ: begin
				state_nxt = abu_pkg::ST_ACTIVE;
			end
			abu_pkg::ST_ACTIVE: begin
				if (cpu_rti_done) begin
					state_nxt = abu_pkg::ST_IDLE; // [R5]
				end
			end
			default: begin
				state_nxt = abu_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			state_r <= abu_pkg::ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign in_break_nxt = (state_nxt == abu_pkg::ST_REQ) || (state_nxt == abu_pkg::ST_ACTIVE);

	// request pulse and swi forcing, both from flops
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			breakpoint_request <= 1'b0;
			force_swi_instr <= 1'b0;
		end else begin
			breakpoint_request <= (state_nxt == abu_pkg::ST_REQ); // [R1]
			force_swi_instr <= (state_nxt == abu_pkg::ST_REQ); // [R3]
		end
	end

	// vector follows monitor mode continuously
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			break_vector <= abu_pkg::VEC_NORMAL;
		end else if (monitor_mode) begin
			break_vector <= abu_pkg::VEC_MONITOR; // [R3]
		end else begin
			break_vector <= abu_pkg::VEC_NORMAL; // [R3]
		end
	end

	// break state side effects on other modules
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			break_state <= 1'b0;
			status_clear_allow <= 1'b1;
			timer_freeze <= 1'b0;
			watchdog_halt <= 1'b0;
		end else begin
			break_state <= in_break_nxt;
			status_clear_allow <= ~in_break_nxt | flag_clear_en_r; // [R15]
			timer_freeze <= in_break_nxt; // [R16]
			watchdog_halt <= in_break_nxt & monitor_mode & wd_disable_r; // [R17]
		end
	end

	// read data, one cycle after the strobe, zero otherwise
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			reg_rdata <= abu_pkg::RST_BYTE;
		end else if (!reg_rd) begin
			reg_rdata <= abu_pkg::RST_BYTE;
		end else if (reg_addr == abu_pkg::ADDR_CTRL_STATUS) begin
			reg_rdata <= {break_enable_r, break_active_r, 6'h00};
		end else if (reg_addr == abu_pkg::ADDR_BRK_HIGH) begin
			reg_rdata <= addr_high_r;
		end else if (reg_addr == abu_pkg::ADDR_BRK_LOW) begin
			reg_rdata <= addr_low_r;
		end else if (reg_addr == abu_pkg::ADDR_AUXILIARY) begin
			reg_rdata <= {7'h00, wd_disable_r};
		end else if (reg_addr == abu_pkg::ADDR_WAIT_STATUS) begin
			reg_rdata <= {6'h00, wait_exit_r, 1'b0}; // [R20]
		end else if (reg_addr == abu_pkg::ADDR_FLAG_CLEAR) begin
			reg_rdata <= {flag_clear_en_r, 7'h00};
		end else begin
			reg_rdata <= abu_pkg::RST_BYTE;
		end
	end
endmodule

// *** abu_top_tb.sv ***
// self-checking bench for the breakpoint unit with a cpu stand-in
// assumes 125 MHz ref_clk and results noted in order in one queue
module abu_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk, rst_b, reg_wr, reg_rd, rd_d, go, cpu_low_power, cpu_wait_mode, monitor_mode;
	logic cpu_bus_cycle, cpu_addr_from_pc, cpu_opcode_fetch, cpu_instr_boundary, cpu_rti_done;
	logic breakpoint_request, force_swi_instr, break_state, status_clear_allow;
	logic timer_freeze, watchdog_halt;
	logic [2:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, lfsr;
	logic [15:0] cpu_addr, break_vector;
	logic [16:0] exp_q[$];
	int errors = 0;
	int checked = 0;
	abu_top u_dut (.*);
	abu_cpu_model u_cpu (.*);
	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	function automatic logic [7:0] step(logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	task automatic check(logic [16:0] seen, logic [16:0] exp, string what);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// one register access and an idle cycle; a read notes its expected byte
	task automatic acc(logic w, logic [2:0] a, logic [7:0] d);
		if (!w)
			exp_q.push_back({9'h000, d});
		reg_wr <= w;
		reg_rd <= !w;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		@(posedge ref_clk);
	endtask
	// sampled on falling edges, away from the updates
	task automatic wait_bst(logic v);
		int n = 0;
		do begin
			@(negedge ref_clk);
			n++;
		end while (break_state !== v && n < 300);
		@(posedge ref_clk);
		if (n >= 300) begin
			errors++;
			give_verdict();
		end
	endtask
	// scoreboard: a result without a note is an error too
	always @(posedge ref_clk) begin
		rd_d <= reg_rd;
		if (rd_d || breakpoint_request) begin
			if (exp_q.size() == 0)
				check(17'h1ffff, 17'h00000, "unexpected result");
			else if (rd_d)
				check({9'h000, reg_rdata}, exp_q.pop_front(), "read data");
			else
				check({break_vector, cpu_addr[0]}, exp_q.pop_front(), "break vector");
		end
	end
	initial begin
		{rst_b, reg_wr, reg_rd, go, cpu_wait_mode, monitor_mode} = 6'h00;
		{reg_addr, reg_wdata, cpu_low_power, lfsr} = {3'h0, 8'h00, 1'b1, 8'h14};
		repeat (5) @(posedge ref_clk);
		rst_b <= 1'b1;
		@(posedge ref_clk);
		for (int i = 0; i < 8; i++)
			acc(0, 3'(i), 8'h00);
		repeat (4) begin
			lfsr = step(lfsr);
			acc(1, abu_pkg::ADDR_BRK_HIGH, lfsr);
			acc(1, abu_pkg::ADDR_BRK_LOW, ~lfsr);
			acc(0, abu_pkg::ADDR_BRK_HIGH, lfsr);
			acc(0, abu_pkg::ADDR_BRK_LOW, ~lfsr);
		end
		// parked cpu keeps fetching the break address in low power
		acc(1, abu_pkg::ADDR_BRK_HIGH, 8'h01);
		acc(1, abu_pkg::ADDR_BRK_LOW, 8'h00);
		acc(1, abu_pkg::ADDR_CTRL_STATUS, 8'h80);
		repeat (20) @(posedge ref_clk);
		acc(1, abu_pkg::ADDR_BRK_HIGH, 8'h00);
		acc(1, abu_pkg::ADDR_BRK_LOW, 8'h80);
		cpu_low_power <= 1'b0;
		go <= 1'b1;
		repeat (40) @(posedge ref_clk);
		go <= 1'b0;
		acc(1, abu_pkg::ADDR_BRK_HIGH, 8'h01);
		acc(1, abu_pkg::ADDR_BRK_LOW, 8'h04);
		exp_q.push_back({abu_pkg::VEC_NORMAL, 1'b1});
		go <= 1'b1;
		wait_bst(1);
		acc(0, abu_pkg::ADDR_CTRL_STATUS, 8'hc0);
		check({16'h0000, status_clear_allow}, 17'h00000, "clear allow");
		acc(1, abu_pkg::ADDR_BRK_LOW, 8'h07);
		acc(1, abu_pkg::ADDR_CTRL_STATUS, 8'h80);
		exp_q.push_back({abu_pkg::VEC_NORMAL, 1'b0});
		wait_bst(0);
		wait_bst(1);
		// flag cleared, address left: a second pass must not break
		acc(1, abu_pkg::ADDR_CTRL_STATUS, 8'h80);
		wait_bst(0);
		go <= 1'b0;
		@(posedge ref_clk);
		go <= 1'b1;
		repeat (40) @(posedge ref_clk);
		acc(0, abu_pkg::ADDR_CTRL_STATUS, 8'h80);
		monitor_mode <= 1'b1;
		cpu_wait_mode <= 1'b1;
		acc(1, abu_pkg::ADDR_AUXILIARY, 8'h01);
		acc(1, abu_pkg::ADDR_FLAG_CLEAR, 8'h80);
		exp_q.push_back({abu_pkg::VEC_MONITOR, 1'b0});
		acc(1, abu_pkg::ADDR_CTRL_STATUS, 8'h40);
		wait_bst(1);
		check({14'h0000, watchdog_halt, status_clear_allow, timer_freeze}, 17'h7, "outs");
		acc(0, abu_pkg::ADDR_WAIT_STATUS, 8'h02);
		acc(1, abu_pkg::ADDR_WAIT_STATUS, 8'h00);
		acc(0, abu_pkg::ADDR_WAIT_STATUS, 8'h00);
		acc(0, abu_pkg::ADDR_AUXILIARY, 8'h01);
		acc(0, abu_pkg::ADDR_FLAG_CLEAR, 8'h80);
		acc(0, abu_pkg::ADDR_CTRL_STATUS, 8'h40);
		acc(1, abu_pkg::ADDR_CTRL_STATUS, 8'h00);
		wait_bst(0);
		check(17'(exp_q.size()), 17'h00000, "pending notes");
		give_verdict();
	end
endmodule
